/* File: rtl/rtcpt_pkg.sv */
// Package for the real-time counter with periodic tick timer.
// Assumes a single core clock; the slow timebase arrives as a sampled input.
package rtcpt_pkg;

	// Register offsets on the byte-wide register port.
	localparam logic [4:0] OFF_CONTROL_A   = 5'h00;
	localparam logic [4:0] OFF_SYNC_STATUS = 5'h01;
	localparam logic [4:0] OFF_IRQ_ENABLE  = 5'h02;
	localparam logic [4:0] OFF_IRQ_FLAGS   = 5'h03;
	localparam logic [4:0] OFF_WIDE_LATCH  = 5'h04;
	localparam logic [4:0] OFF_HALT_CTRL   = 5'h05;
	localparam logic [4:0] OFF_CORRECTION  = 5'h06;
	localparam logic [4:0] OFF_TB_SOURCE   = 5'h07;
	localparam logic [4:0] OFF_COUNT_LO    = 5'h08;
	localparam logic [4:0] OFF_COUNT_HI    = 5'h09;
	localparam logic [4:0] OFF_LIMIT_LO    = 5'h0A;
	localparam logic [4:0] OFF_LIMIT_HI    = 5'h0B;
	localparam logic [4:0] OFF_MATCH_LO    = 5'h0C;
	localparam logic [4:0] OFF_MATCH_HI    = 5'h0D;
	localparam logic [4:0] OFF_TICK_CTRL   = 5'h10;
	localparam logic [4:0] OFF_TICK_STATUS = 5'h11;
	localparam logic [4:0] OFF_TICK_IEN    = 5'h12;
	localparam logic [4:0] OFF_TICK_FLAGS  = 5'h13;
	localparam logic [4:0] OFF_TICK_HALT   = 5'h15;

	// Field positions.
	localparam int BIT_STANDBY_RUN = 7;
	localparam int BIT_PRESC_HI    = 6;
	localparam int BIT_PRESC_LO    = 3;
	localparam int BIT_FIX_ENABLE  = 2;
	localparam int BIT_ENABLE      = 0;
	localparam int BIT_MATCH       = 1;
	localparam int BIT_WRAP        = 0;
	localparam int BIT_CORR_SIGN   = 7;

	// Writable masks; unassigned bits read as zero.
	localparam logic [7:0] MASK_CONTROL_A = 8'hFD;
	localparam logic [7:0] MASK_TICK_CTRL = 8'h79;
	localparam logic [7:0] MASK_TB_SOURCE = 8'h03;

	// Reset values.
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_LIMIT = 16'hFFFF;
	localparam logic [15:0] RST_MATCH = 16'h0000;

	// Synchronisation channels, one busy flag each.
	localparam int SYNC_CH    = 5;
	localparam int CH_CTRL_A  = 0;
	localparam int CH_COUNT   = 1;
	localparam int CH_LIMIT   = 2;
	localparam int CH_MATCH   = 3;
	localparam int CH_TICK    = 4;
	localparam logic [1:0] SYNC_EDGES = 2'h2;

	// Crystal correction interval in slow clock cycles.
	localparam logic [19:0] CORR_SPAN = 20'hF4240;
	localparam int PRESC_W = 15;

endpackage

/* File: rtl/rtcpt_core.sv */
// Real-time counter and periodic tick timer with sync busy flags.
// Assumes timebase_clk is a slow clock already synchronous to core_clk.
// Software uses a plain byte register port with read data one cycle late.

// Function
// - Counter keeps counting in idle sleep with no configuration needed.
// - Counter runs in standby only when standby_run is set.
// - Tick timer runs in every sleep state regardless of standby_run.
// - Both count from the slow timebase; updates cross with a delay.
// - Sync status shows match, limit, count and control A busy bits.
// - Tick timer status shows busy while its control write synchronises.
// - Prescaler change takes effect two slow clock cycles after writing.
// - Prescaler field divides slow clock by two to the field value.
// - Control A bit 2 enables crystal frequency correction.
// - Control A bit 0 enables the counter; control A resets to zero.
// - Without run_during_halt the counter stops during debug halt.
// - Without its halt bit the tick output is forced low in halt.
// - Divided clock high at resume gives a new rising edge and extra flag.
// - Divided clock low at resume keeps output low with no extra interrupt.
// - Interrupt enable bit 1 enables the match interrupt.
// - Interrupt enable bit 0 enables the wrap interrupt.
// - Flag bit 1 sets when count equals match_value.
// - Flag bit 0 sets when count reaches wrap_limit and rolls to zero.
// - Writing one clears a flag; writing zero leaves it alone.
// - Tick output toggles every half period after the first interrupt.
// - Shared prescaler stops only when counter and tick timer are off.
// - Interrupt request stays high while enabled and flag is set.
module rtcpt_core
	import rtcpt_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [4:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       timebase_clk,
	input  wire logic       sleep_standby,
	input  wire logic       debug_halt,
	output logic            counter_irq,
	output logic            tick_irq,
	output logic            tick_timer_out,
	output logic            counter_wrap_event,
	output logic            match_event
);

	typedef struct packed {
		logic [7:0]           rdata;
		logic [7:0]           control_a;
		logic [7:0]           control_a_act;
		logic [1:0]           irq_enable;
		logic [1:0]           irq_flags;
		logic [7:0]           temp;
		logic                 run_during_halt;
		logic [7:0]           crystal_correction;
		logic [1:0]           timebase_source;
		logic [15:0]          count_value;
		logic [15:0]          count_pend;
		logic [15:0]          wrap_limit;
		logic [15:0]          wrap_limit_act;
		logic [15:0]          match_value;
		logic [15:0]          match_value_act;
		logic [7:0]           tick_ctrl;
		logic [7:0]           tick_ctrl_act;
		logic                 tick_ien;
		logic                 tick_flag;
		logic                 tick_halt_run;
		logic [SYNC_CH-1:0]   busy;
		logic [SYNC_CH*2-1:0] edges;
		logic                 tb_prev;
		logic [PRESC_W-1:0]   presc;
		logic [19:0]          corr_acc;
		logic                 tick_out;
		logic                 wrap_evt;
		logic                 match_evt;
	} rtcpt_state_t;

	rtcpt_state_t       s;
	rtcpt_state_t       next_s;
	logic [SYNC_CH-1:0] apply;
	logic               slow_edge;
	logic               presc_run;
	logic               counter_run;
	logic               tick;
	logic [1:0]         step;
	logic [PRESC_W-1:0] presc_new;
	logic [PRESC_W-1:0] mask;
	logic [19:0]        acc_sum;
	logic [15:0]        count_new;
	logic [3:0]         tick_sel;
	logic               tick_raw;
	logic               tick_gated;

	// All next-state logic. Order matters: bus clears come before
	// hardware sets so that an event in a clearing cycle survives, and
	// synchronised values land last so they override a counter step.
	always_comb begin
		next_s = s;
		next_s.rdata = RST_BYTE;
		next_s.wrap_evt = 1'b0;
		next_s.match_evt = 1'b0;
		slow_edge = timebase_clk & ~s.tb_prev;
		next_s.tb_prev = timebase_clk;
		apply = '0;

		// Each pending write waits two slow edges before it applies.
		for (int i = 0; i < SYNC_CH; i++) begin
			if (s.busy[i] && slow_edge) begin
				if (s.edges[i*2 +: 2] == SYNC_EDGES - 2'h1) begin
					apply[i] = 1'b1;
					next_s.busy[i] = 1'b0;
					next_s.edges[i*2 +: 2] = 2'h0;
				end else begin
					next_s.edges[i*2 +: 2] = s.edges[i*2 +: 2] + 2'h1;
				end
			end
		end

		// Register reads; wide low-byte reads capture the high byte.
		if (rd) begin
			case (addr)
				OFF_CONTROL_A:   next_s.rdata = s.control_a;
				OFF_SYNC_STATUS: next_s.rdata = {4'h0, s.busy[3:0]};
				OFF_IRQ_ENABLE:  next_s.rdata = {6'h00, s.irq_enable};
				OFF_IRQ_FLAGS:   next_s.rdata = {6'h00, s.irq_flags};
				OFF_WIDE_LATCH:  next_s.rdata = s.temp;
				OFF_HALT_CTRL:   next_s.rdata = {7'h00, s.run_during_halt};
				OFF_CORRECTION:  next_s.rdata = s.crystal_correction;
				OFF_TB_SOURCE:   next_s.rdata = {6'h00, s.timebase_source};
				OFF_COUNT_LO: begin
					next_s.rdata = s.count_value[7:0];
					next_s.temp = s.count_value[15:8];
				end
				OFF_LIMIT_LO: begin
					next_s.rdata = s.wrap_limit[7:0];
					next_s.temp = s.wrap_limit[15:8];
				end
				OFF_MATCH_LO: begin
					next_s.rdata = s.match_value[7:0];
					next_s.temp = s.match_value[15:8];
				end
				OFF_COUNT_HI, OFF_LIMIT_HI, OFF_MATCH_HI:
					next_s.rdata = s.temp;
				OFF_TICK_CTRL:   next_s.rdata = s.tick_ctrl;
				OFF_TICK_STATUS: next_s.rdata = {7'h00, s.busy[CH_TICK]};
				OFF_TICK_IEN:    next_s.rdata = {7'h00, s.tick_ien};
				OFF_TICK_FLAGS:  next_s.rdata = {7'h00, s.tick_flag};
				OFF_TICK_HALT:   next_s.rdata = {7'h00, s.tick_halt_run};
				default:         next_s.rdata = RST_BYTE;
			endcase
		end

		// Register writes; unassigned bits are masked off.
		if (wr) begin
			case (addr)
				OFF_CONTROL_A: begin
					next_s.control_a = wdata & MASK_CONTROL_A;
					next_s.busy[CH_CTRL_A] = 1'b1;
					next_s.edges[CH_CTRL_A*2 +: 2] = 2'h0;
				end
				OFF_IRQ_ENABLE: next_s.irq_enable = wdata[1:0];
				OFF_IRQ_FLAGS:  next_s.irq_flags = s.irq_flags & ~wdata[1:0];
				OFF_WIDE_LATCH: next_s.temp = wdata;
				OFF_HALT_CTRL:  next_s.run_during_halt = wdata[0];
				OFF_CORRECTION: next_s.crystal_correction = wdata;
				OFF_TB_SOURCE:  next_s.timebase_source = wdata[1:0];
				OFF_COUNT_LO, OFF_LIMIT_LO, OFF_MATCH_LO:
					next_s.temp = wdata;
				OFF_COUNT_HI: begin
					next_s.count_pend = {wdata, s.temp};
					next_s.busy[CH_COUNT] = 1'b1;
					next_s.edges[CH_COUNT*2 +: 2] = 2'h0;
				end
				OFF_LIMIT_HI: begin
					next_s.wrap_limit = {wdata, s.temp};
					next_s.busy[CH_LIMIT] = 1'b1;
					next_s.edges[CH_LIMIT*2 +: 2] = 2'h0;
				end
				OFF_MATCH_HI: begin
					next_s.match_value = {wdata, s.temp};
					next_s.busy[CH_MATCH] = 1'b1;
					next_s.edges[CH_MATCH*2 +: 2] = 2'h0;
				end
				OFF_TICK_CTRL: begin
					next_s.tick_ctrl = wdata & MASK_TICK_CTRL;
					next_s.busy[CH_TICK] = 1'b1;
					next_s.edges[CH_TICK*2 +: 2] = 2'h0;
				end
				OFF_TICK_IEN:   next_s.tick_ien = wdata[0];
				OFF_TICK_FLAGS: next_s.tick_flag = s.tick_flag & ~wdata[0];
				OFF_TICK_HALT:  next_s.tick_halt_run = wdata[0];
				default: ;
			endcase
		end

		// Shared prescaler runs while either function is on.
		presc_run = s.control_a_act[BIT_ENABLE] | s.tick_ctrl_act[BIT_ENABLE];
		acc_sum = s.corr_acc + {13'h0000, s.crystal_correction[6:0]};
		step = 2'h1;
		if (s.control_a_act[BIT_FIX_ENABLE] && acc_sum >= CORR_SPAN) begin
			// Slower crystal fix drops a step, faster fix doubles one.
			step = s.crystal_correction[BIT_CORR_SIGN] ? 2'h2 : 2'h0;
		end
		presc_new = s.presc + {{(PRESC_W-2){1'b0}}, step};
		mask = PRESC_W'((16'h0001 << s.control_a_act[BIT_PRESC_HI:BIT_PRESC_LO])
			- 16'h0001);
		tick = 1'b0;
		if (presc_run && slow_edge) begin
			next_s.presc = presc_new;
			if (s.control_a_act[BIT_FIX_ENABLE]) begin
				next_s.corr_acc = (acc_sum >= CORR_SPAN) ? acc_sum - CORR_SPAN
					: acc_sum;
			end
			tick = (step != 2'h0) && ((mask == '0)
				|| ((presc_new & mask) < (s.presc & mask)));
		end

		// Counter; idle sleep has no effect, standby and halt may stop it.
		counter_run = s.control_a_act[BIT_ENABLE]
			&& !(sleep_standby && !s.control_a_act[BIT_STANDBY_RUN])
			&& !(debug_halt && !s.run_during_halt);
		count_new = s.count_value + 16'h0001;
		if (tick && counter_run) begin
			if (s.count_value == s.wrap_limit_act) begin
				count_new = RST_COUNT;
				next_s.irq_flags[BIT_WRAP] = 1'b1;
				next_s.wrap_evt = 1'b1;
			end
			next_s.count_value = count_new;
			if (count_new == s.match_value_act) begin
				next_s.irq_flags[BIT_MATCH] = 1'b1;
				next_s.match_evt = 1'b1;
			end
		end

		// Tick timer ignores sleep; halt forces its output low and the
		// edge detector then yields the extra flag on resume if needed.
		tick_sel = s.tick_ctrl_act[BIT_PRESC_HI:BIT_PRESC_LO];
		tick_raw = s.tick_ctrl_act[BIT_ENABLE] && (tick_sel != 4'h0)
			&& s.presc[4'(tick_sel - 4'h1)];
		tick_gated = tick_raw && !(debug_halt && !s.tick_halt_run);
		next_s.tick_out = tick_gated;
		if (tick_gated && !s.tick_out) begin
			next_s.tick_flag = 1'b1;
		end

		// Land synchronised values in the slow domain.
		if (apply[CH_CTRL_A]) next_s.control_a_act = s.control_a;
		if (apply[CH_COUNT])  next_s.count_value = s.count_pend;
		if (apply[CH_LIMIT])  next_s.wrap_limit_act = s.wrap_limit;
		if (apply[CH_MATCH])  next_s.match_value_act = s.match_value;
		if (apply[CH_TICK])   next_s.tick_ctrl_act = s.tick_ctrl;
	end

	// State register with synchronous active-low reset.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s <= '0;
			s.wrap_limit <= RST_LIMIT;
			s.wrap_limit_act <= RST_LIMIT;
		end else begin
			s <= next_s;
		end
	end

	// Requests stay up while enabled flags are set.
	assign counter_irq = |(s.irq_flags & s.irq_enable);
	assign tick_irq = s.tick_flag & s.tick_ien;
	assign rdata = s.rdata;
	assign tick_timer_out = s.tick_out;
	assign counter_wrap_event = s.wrap_evt;
	assign match_event = s.match_evt;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// Every synchronised register raises its busy flag one cycle after
	// the write, so software polling straight away never sees a stale zero.
	a_busy_after_write: assert property (
		wr && addr == OFF_CONTROL_A |=> s.busy[CH_CTRL_A]
		&& s.control_a == ($past(wdata) & MASK_CONTROL_A))
		else $error("control busy did not rise");

	a_count_busy: assert property (
		wr && addr == OFF_COUNT_HI |=> s.busy[CH_COUNT])
		else $error("count busy did not rise");

	a_limit_busy: assert property (
		wr && addr == OFF_LIMIT_HI |=> s.busy[CH_LIMIT])
		else $error("limit busy did not rise");

	a_match_busy: assert property (
		wr && addr == OFF_MATCH_HI |=> s.busy[CH_MATCH])
		else $error("match busy did not rise");

	a_tick_busy: assert property (
		wr && addr == OFF_TICK_CTRL |=> s.busy[CH_TICK])
		else $error("tick busy did not rise");

	a_limit_apply: assert property (
		$fell(s.busy[CH_LIMIT]) && !$past(wr)
		|-> s.wrap_limit_act == s.wrap_limit)
		else $error("limit value not applied when busy fell");

	a_status_read: assert property (
		rd && addr == OFF_SYNC_STATUS |=> rdata == {4'h0, $past(s.busy[3:0])})
		else $error("status read mismatch");

	a_prescale_apply: assert property (
		$fell(s.busy[CH_CTRL_A]) && !$past(wr)
		|-> s.control_a_act == s.control_a)
		else $error("control value not applied when busy fell");

	a_standby_hold: assert property (
		sleep_standby && !s.control_a_act[BIT_STANDBY_RUN]
		&& !apply[CH_COUNT] |=> $stable(s.count_value))
		else $error("counter moved in standby");

	a_halt_hold: assert property (
		debug_halt && !s.run_during_halt && !apply[CH_COUNT]
		|=> $stable(s.count_value)) else $error("counter moved in halt");

	a_tick_low_halt: assert property (
		debug_halt && !s.tick_halt_run |=> !tick_timer_out)
		else $error("tick output not low in halt");

	a_wrap_zero: assert property (
		tick && counter_run && s.count_value == s.wrap_limit_act
		&& !apply[CH_COUNT] |=> s.count_value == 16'h0000
		&& s.irq_flags[BIT_WRAP] && counter_wrap_event)
		else $error("wrap did not roll to zero");

	a_match_flag: assert property (
		tick && counter_run && !apply[CH_COUNT]
		&& s.count_value != s.wrap_limit_act
		&& s.count_value + 16'h0001 == s.match_value_act
		|=> s.irq_flags[BIT_MATCH] && match_event)
		else $error("match did not set flag");

	// Only a hardware set in the same cycle may keep a cleared flag up.
	a_flag_clear: assert property (
		wr && addr == OFF_IRQ_FLAGS && !(tick && counter_run)
		|=> (s.irq_flags & $past(wdata[BIT_MATCH:BIT_WRAP])) == 2'h0)
		else $error("flag write did not clear");

	a_presc_stop: assert property (
		!presc_run |=> $stable(s.presc)) else $error("prescaler ran off");

	a_tick_flag_edge: assert property (
		$rose(tick_timer_out) |-> s.tick_flag)
		else $error("tick edge did not set flag");

	// A break that forced the output low gives one fresh edge on resume
	// only when the divided clock is high at that moment.
	a_resume_edge: assert property (
		debug_halt && !s.tick_halt_run ##1 !debug_halt && tick_raw
		|=> tick_timer_out && s.tick_flag)
		else $error("no extra tick edge on resume");

	a_resume_low: assert property (
		debug_halt && !s.tick_halt_run ##1 !debug_halt && !tick_raw
		|=> !tick_timer_out && !$rose(s.tick_flag))
		else $error("tick resumed with an extra edge");

	a_irq_level: assert property (
		s.irq_flags[BIT_MATCH] && s.irq_enable[BIT_MATCH] |-> counter_irq)
		else $error("match request not raised");

	c_wrap: cover property (counter_wrap_event);
	c_flag_clear: cover property (wr && addr == OFF_IRQ_FLAGS && |s.irq_flags);
	c_match: cover property (match_event && counter_irq);
	c_tick_resume: cover property ($fell(debug_halt) ##1 $rose(tick_timer_out));
	c_busy_cycle: cover property ($rose(s.busy[CH_TICK]) ##[1:200]
		$fell(s.busy[CH_TICK]));

endmodule

/* File: test/rtcpt_tb.sv */
// Self-checking bench for the real-time counter and tick timer core.
// Assumes rtcpt_pkg is compiled first; the bench makes the slow timebase.
module tb
	import rtcpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       core_clk      = 1'b0;
	logic       resetn        = 1'b0;
	logic [4:0] addr          = 5'h00;
	logic [7:0] wdata         = 8'h00;
	logic       wr            = 1'b0;
	logic       rd            = 1'b0;
	logic       timebase_clk  = 1'b0;
	logic       sleep_standby = 1'b0;
	logic       debug_halt    = 1'b0;
	logic [1:0] tb_div        = 2'h0;
	logic [7:0] rdata;
	logic       counter_irq;
	logic       tick_irq;
	logic       tick_timer_out;
	logic       counter_wrap_event;
	logic       match_event;
	int         fail_count      = 0;
	int         samples_checked = 0;
	int         wrap_pulses     = 0;
	int         match_pulses    = 0;

	rtcpt_core rtcpt_core_i (
		.core_clk          (core_clk),
		.resetn            (resetn),
		.addr              (addr),
		.wdata             (wdata),
		.wr                (wr),
		.rd                (rd),
		.rdata             (rdata),
		.timebase_clk      (timebase_clk),
		.sleep_standby     (sleep_standby),
		.debug_halt        (debug_halt),
		.counter_irq       (counter_irq),
		.tick_irq          (tick_irq),
		.tick_timer_out    (tick_timer_out),
		.counter_wrap_event(counter_wrap_event),
		.match_event       (match_event)
	);

	// Clock of 20 ns period.
	always #10 core_clk = ~core_clk;

	// Slow timebase: three core cycles high, three low, so edges are seen.
	always @(posedge core_clk) begin
		tb_div <= (tb_div == 2'h2) ? 2'h0 : tb_div + 2'h1;
		if (tb_div == 2'h2) begin
			timebase_clk <= ~timebase_clk;
		end
		if (counter_wrap_event === 1'b1) begin
			wrap_pulses <= wrap_pulses + 1;
		end
		if (match_event === 1'b1) begin
			match_pulses <= match_pulses + 1;
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Write strobe is held for one cycle; an idle cycle follows each call.
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	// Read data is taken just after the edge that registers it.
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge core_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic wr16(input logic [4:0] a, input logic [15:0] v);
		wr_reg(a, v[7:0]);
		wr_reg(a + 5'h01, v[15:8]);
	endtask

	task automatic rd16(input logic [4:0] a, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		rd_reg(a, lo);
		rd_reg(a + 5'h01, hi);
		v = {hi, lo};
	endtask

	// Polls a register until the masked bits equal the wanted value.
	task automatic poll(input logic [4:0] a, input logic [7:0] m,
		input logic [7:0] want, input string name);
		logic [7:0] d;
		d = ~want;
		for (int i = 0; i < 80 && (d & m) !== want; i++) begin
			rd_reg(a, d);
		end
		chk(name, {8'h00, want}, {8'h00, d & m});
	endtask

	task automatic t_reset();
		logic [7:0]  d;
		logic [15:0] v;
		rd_reg(OFF_CONTROL_A, d);
		chk("control_a reset", 16'h0000, {8'h00, d});
		rd_reg(OFF_SYNC_STATUS, d);
		chk("sync_status reset", 16'h0000, {8'h00, d});
		rd16(OFF_LIMIT_LO, v);
		chk("wrap_limit reset", 16'hFFFF, v);
		wr_reg(5'h0E, 8'hFF);
		rd_reg(5'h0E, d);
		chk("reserved offset", 16'h0000, {8'h00, d});
		$display("test reset done");
	endtask

	task automatic t_control();
		logic [7:0] d;
		wr_reg(OFF_CONTROL_A, 8'hFF);
		rd_reg(OFF_SYNC_STATUS, d);
		chk("control busy", 16'h0001, {8'h00, d});
		poll(OFF_SYNC_STATUS, 8'h0F, 8'h00, "control busy falls");
		rd_reg(OFF_CONTROL_A, d);
		chk("control_a mask", 16'h00FD, {8'h00, d});
		wr_reg(OFF_CONTROL_A, 8'h00);
		poll(OFF_SYNC_STATUS, 8'h0F, 8'h00, "control idle");
		$display("test control done");
	endtask

	task automatic t_wrap();
		logic [7:0]  d;
		logic [15:0] v;
		wr16(OFF_LIMIT_LO, 16'h0003);
		wr16(OFF_MATCH_LO, 16'h0002);
		wr_reg(OFF_IRQ_ENABLE, 8'h03);
		wr_reg(OFF_CONTROL_A, 8'h01);
		poll(OFF_IRQ_FLAGS, 8'h03, 8'h03, "match and wrap flags");
		chk("counter_irq on", 16'h0001, {15'h0, counter_irq});
		rd16(OFF_COUNT_LO, v);
		chk("count within limit", 16'h0001, {15'h0, v <= 16'h0003});
		chk("wrap pulse seen", 16'h0001, {15'h0, wrap_pulses > 0});
		chk("match pulse seen", 16'h0001, {15'h0, match_pulses > 0});
		wr_reg(OFF_CONTROL_A, 8'h00);
		poll(OFF_SYNC_STATUS, 8'h0F, 8'h00, "stop idle");
		wr_reg(OFF_IRQ_FLAGS, 8'h02);
		rd_reg(OFF_IRQ_FLAGS, d);
		chk("clear match only", 16'h0001, {8'h00, d});
		wr_reg(OFF_IRQ_ENABLE, 8'h02);
		// The new enable lands at the edge that ends the strobe; look after it.
		#1;
		chk("wrap masked", 16'h0000, {15'h0, counter_irq});
		wr_reg(OFF_IRQ_FLAGS, 8'h01);
		rd_reg(OFF_IRQ_FLAGS, d);
		chk("clear wrap", 16'h0000, {8'h00, d});
		$display("test wrap done");
	endtask

	// Reads the count twice and checks whether it moved in between.
	task automatic moved(input logic expect_move, input string name);
		logic [15:0] a;
		logic [15:0] b;
		repeat (4) @(posedge core_clk);
		rd16(OFF_COUNT_LO, a);
		repeat (30) @(posedge core_clk);
		rd16(OFF_COUNT_LO, b);
		chk(name, {15'h0, expect_move}, {15'h0, a != b});
	endtask

	task automatic t_sleep_halt();
		logic [15:0] ca;
		logic [15:0] cb;
		logic [15:0] steps;
		wr16(OFF_LIMIT_LO, 16'hFFFF);
		wr_reg(OFF_HALT_CTRL, 8'h00);
		wr_reg(OFF_CONTROL_A, 8'h01);
		poll(OFF_SYNC_STATUS, 8'h0F, 8'h00, "run idle");
		debug_halt <= 1'b1;
		moved(1'b0, "halted count");
		wr_reg(OFF_HALT_CTRL, 8'h01);
		moved(1'b1, "halt run count");
		debug_halt    <= 1'b0;
		sleep_standby <= 1'b1;
		moved(1'b0, "standby stop");
		wr_reg(OFF_CONTROL_A, 8'h81);
		poll(OFF_SYNC_STATUS, 8'h0F, 8'h00, "standby idle");
		moved(1'b1, "standby run");
		// Divide by four: one count per four slow edges, about ten here.
		wr_reg(OFF_CONTROL_A, 8'h91);
		poll(OFF_SYNC_STATUS, 8'h0F, 8'h00, "divide idle");
		rd16(OFF_COUNT_LO, ca);
		repeat (240) @(posedge core_clk);
		rd16(OFF_COUNT_LO, cb);
		steps = cb - ca;
		chk("div4 low", 16'h0001, {15'h0, steps >= 16'h0009});
		chk("div4 high", 16'h0001, {15'h0, steps <= 16'h000B});
		wr_reg(OFF_CONTROL_A, 8'h00);
		$display("test sleep and halt done");
	endtask

	task automatic t_tick();
		logic [7:0] d;
		logic       hi;
		logic       lo;
		hi = 1'b0;
		lo = 1'b0;
		wr_reg(OFF_TICK_IEN, 8'h01);
		wr_reg(OFF_TICK_CTRL, 8'h09);
		rd_reg(OFF_TICK_STATUS, d);
		chk("tick busy", 16'h0001, {8'h00, d});
		poll(OFF_TICK_FLAGS, 8'h01, 8'h01, "tick flag in standby");
		chk("tick_irq on", 16'h0001, {15'h0, tick_irq});
		for (int i = 0; i < 40; i++) begin
			@(posedge core_clk);
			#1;
			hi = hi | (tick_timer_out === 1'b1);
			lo = lo | (tick_timer_out === 1'b0);
		end
		chk("tick toggles", 16'h0003, {14'h0, hi, lo});
		wr_reg(OFF_TICK_HALT, 8'h00);
		debug_halt <= 1'b1;
		repeat (4) @(posedge core_clk);
		hi = 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(posedge core_clk);
			#1;
			hi = hi | (tick_timer_out !== 1'b0);
		end
		chk("tick low in halt", 16'h0000, {15'h0, hi});
		debug_halt <= 1'b0;
		// Stop the timer first so no late edge sets the flag again.
		wr_reg(OFF_TICK_CTRL, 8'h00);
		poll(OFF_TICK_STATUS, 8'h01, 8'h00, "tick idle");
		wr_reg(OFF_TICK_FLAGS, 8'h01);
		rd_reg(OFF_TICK_FLAGS, d);
		chk("tick flag cleared", 16'h0000, {8'h00, d});
		$display("test tick done");
	endtask

	// A hang in any poll or handshake ends the run here.
	initial begin
		repeat (30000) @(posedge core_clk);
		fail_count++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_control();
		t_wrap();
		t_sleep_halt();
		t_tick();
		wrap_up();
	end
endmodule
